// >>> hdl/bq_pkg.sv
// Shared constants and carriers for the bus event count qualifier.
package bq_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_SEL_FIRST = 8'h00;
   localparam logic [7:0] ADDR_SEL_SECOND = 8'h04;
   localparam logic [7:0] ADDR_CNT_EN = 8'h08;
   localparam logic [7:0] ADDR_MODEL_GEN = 8'h0C;
   localparam logic [7:0] ADDR_CNT_BASE = 8'h10;
   localparam int NUM_CNT = 4;

   localparam logic [31:0] SEL_RST = 32'h0000_0000;
   localparam logic [3:0] CNT_EN_RST = 4'h0;
   localparam logic [3:0] MODEL_GEN_RST = 4'h2;
   localparam logic [3:0] NEW_GEN_MIN = 4'h2;

   // Event select and mask fields inside a select register.
   localparam int EVT_LSB = 25;
   localparam int EVT_MSB = 31;
   localparam int MASK_LSB = 9;
   localparam int MASK_MSB = 24;
   localparam logic [6:0] EVT_DATA_ACT = 7'h17;
   localparam logic [6:0] EVT_QUEUE_ALLOC = 7'h03;

   // Bus data activity mask bits.
   localparam int DM_DRV = 0;
   localparam int DM_OWN = 1;
   localparam int DM_OTHER = 2;

   // Queue allocation mask bits.
   localparam int QM_REQ_MSB = 4;
   localparam int QM_ALL_READ = 5;
   localparam int QM_ALL_WRITE = 6;
   localparam int QM_MEM_LSB = 7;
   localparam int QM_MEM_MSB = 11;
   localparam int QM_OWN = 13;
   localparam int QM_OTHER = 14;
   localparam int QM_PREFETCH = 15;

   // Bus timing facts the counters rely on.
   localparam int LINE_BYTES = 64;
   localparam int CHUNK_BYTES = 8;
   localparam int LINE_STROBE_CLKS = 4;
   localparam int PART_STROBE_CLKS = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic dataReadyStrobe;
      logic dataBusyStrobe;
      logic selfDrives;
      logic selfSamples;
   } bq_bus_t;

   typedef struct packed {
      logic valid;
      logic [4:0] reqType;
      logic isRead;
      logic isWrite;
      logic [4:0] memType;
      logic ownAgent;
      logic otherAgent;
      logic prefetch;
      logic isLine;
      logic userLevel;
   } bq_alloc_t;

   function automatic logic [6:0] evt_field(input logic [31:0] r);
      return r[EVT_MSB:EVT_LSB];
   endfunction

   function automatic logic [15:0] mask_field(input logic [31:0] r);
      return r[MASK_MSB:MASK_LSB];
   endfunction

endpackage

// >>> hdl/bq_data_activity.sv
// Data-ready condition selection for the bus data activity event.
`timescale 1ns/1ps
module bq_data_activity
   import bq_pkg::*;
(
   // Bus view and mask.
   input wire bq_bus_t bus,
   input wire logic [15:0] mask,
   // Qualified event.
   output logic hit
);
   logic drv;
   logic own;
   logic other;

   assign drv = bus.dataReadyStrobe & bus.selfDrives;
   assign own = bus.dataReadyStrobe & bus.selfSamples;
   // Data on the bus that this end does not sample, whoever drives it.
   assign other = bus.dataReadyStrobe & ~bus.selfSamples;
   assign hit = (mask[DM_DRV] & drv) | (mask[DM_OWN] & own)
      | (mask[DM_OTHER] & other);
endmodule // bq_data_activity

// >>> hdl/bq_queue_alloc.sv
// Trigger expression for the queue allocation event.
`timescale 1ns/1ps
module bq_queue_alloc
   import bq_pkg::*;
(
   // Allocation view, mask and model generation.
   input wire bq_alloc_t alloc,
   input wire logic [15:0] mask,
   input wire logic [3:0] modelGen,
   // Qualified event.
   output logic hit
);
   logic reqM;
   logic rwM;
   logic memM;
   logic srcM;
   logic oldMem;

   assign reqM = mask[QM_REQ_MSB:0] == alloc.reqType;
   assign rwM = (mask[QM_ALL_READ] & alloc.isRead)
      | (mask[QM_ALL_WRITE] & alloc.isWrite);
   assign memM = |(mask[QM_MEM_MSB:QM_MEM_LSB] & alloc.memType);
   assign srcM = ((mask[QM_OWN] & alloc.ownAgent)
      | (mask[QM_OTHER] & alloc.otherAgent))
      & (~alloc.prefetch | mask[QM_PREFETCH]);
   assign oldMem = memM & ~(mask[QM_ALL_READ] | mask[QM_ALL_WRITE]);

   // Privilege level is never looked at, and size does not change weight.
   always_comb begin
      if (modelGen >= NEW_GEN_MIN) begin
         hit = alloc.valid & reqM & rwM & memM & srcM;
      end else begin
         hit = alloc.valid & (reqM | rwM | oldMem) & srcM;
      end
   end
endmodule // bq_queue_alloc

// >>> hdl/bq_top.sv
// Bus event count qualifier with four counters behind AXI4-Lite.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module bq_top
   import bq_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Observed bus activity.
   input wire bq_bus_t bus,
   input wire bq_alloc_t alloc,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Per-counter increment pulses.
   output logic [NUM_CNT-1:0] incPulse
);
   logic [31:0] sel_ff [2];
   logic [3:0] cntEn_ff;
   logic [3:0] modelGen_ff;
   logic [31:0] cnt_ff [NUM_CNT];
   logic [NUM_CNT-1:0] inc_ff;
   logic awRdy_ff;
   logic wRdy_ff;
   logic bValid_ff;
   logic [1:0] bResp_ff;
   logic [7:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic arRdy_ff;
   logic rValid_ff;
   logic [1:0] rResp_ff;
   logic [31:0] rData_ff;
   logic wrFire;
   logic [1:0] dataHit;
   logic [1:0] qHit;
   logic [NUM_CNT-1:0] nxt_inc;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Index of a counter register, or NUM_CNT when the address is not one.
   function automatic int cnt_index(input logic [7:0] a);
      for (int i = 0; i < NUM_CNT; i++) begin
         if (a == ADDR_CNT_BASE + 8'(4 * i)) begin
            return i;
         end
      end
      return NUM_CNT;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == ADDR_SEL_FIRST || a == ADDR_SEL_SECOND
         || a == ADDR_CNT_EN || a == ADDR_MODEL_GEN || cnt_index(a) < NUM_CNT;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Event qualification, one pair of qualifiers per select register.
   for (genvar g = 0; g < 2; g++) begin : gQual
      bq_data_activity uData (
         .bus(bus),
         .mask(mask_field(sel_ff[g])),
         .hit(dataHit[g])
      );
      bq_queue_alloc uQueue (
         .alloc(alloc),
         .mask(mask_field(sel_ff[g])),
         .modelGen(modelGen_ff),
         .hit(qHit[g])
      );
   end

   // Counters 2k and 2k+1 both follow select register k.
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         unique case (evt_field(sel_ff[i / 2]))
            EVT_DATA_ACT: nxt_inc[i] = dataHit[i / 2] & cntEn_ff[i];
            EVT_QUEUE_ALLOC: nxt_inc[i] = qHit[i / 2] & cntEn_ff[i];
            default: nxt_inc[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         inc_ff <= '0;
      end else begin
         inc_ff <= nxt_inc;
      end
   end

   // A software load of a counter wins over an increment in the same cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt_ff[i] <= 32'h0000_0000;
         end
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (wrFire && cnt_index(awAddr_ff) == i) begin
               cnt_ff[i] <= merge_bytes(cnt_ff[i], wData_ff, wStrb_ff);
            end else if (nxt_inc[i]) begin
               cnt_ff[i] <= cnt_ff[i] + 32'h0000_0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write path: address and data are held until both have arrived.
   assign wrFire = !awRdy_ff && !wRdy_ff && !bValid_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awRdy_ff <= 1'b1;
         wRdy_ff <= 1'b1;
         bValid_ff <= 1'b0;
         bResp_ff <= RESP_OKAY;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
      end else begin
         if (awRdy_ff && s_axi_awvalid) begin
            awRdy_ff <= 1'b0;
            awAddr_ff <= s_axi_awaddr;
         end
         if (wRdy_ff && s_axi_wvalid) begin
            wRdy_ff <= 1'b0;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (wrFire) begin
            bValid_ff <= 1'b1;
            bResp_ff <= addr_mapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bValid_ff && s_axi_bready) begin
            bValid_ff <= 1'b0;
            awRdy_ff <= 1'b1;
            wRdy_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_ff[0] <= SEL_RST;
         sel_ff[1] <= SEL_RST;
         cntEn_ff <= CNT_EN_RST;
         modelGen_ff <= MODEL_GEN_RST;
      end else if (wrFire) begin
         case (awAddr_ff)
            ADDR_SEL_FIRST:
               sel_ff[0] <= merge_bytes(sel_ff[0], wData_ff, wStrb_ff);
            ADDR_SEL_SECOND:
               sel_ff[1] <= merge_bytes(sel_ff[1], wData_ff, wStrb_ff);
            ADDR_CNT_EN: begin
               if (wStrb_ff[0]) begin
                  cntEn_ff <= wData_ff[3:0];
               end
            end
            ADDR_MODEL_GEN: begin
               if (wStrb_ff[0]) begin
                  modelGen_ff <= wData_ff[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path: one cycle from address to data.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arRdy_ff <= 1'b1;
         rValid_ff <= 1'b0;
         rResp_ff <= RESP_OKAY;
         rData_ff <= 32'h0000_0000;
      end else if (arRdy_ff && s_axi_arvalid) begin
         arRdy_ff <= 1'b0;
         rValid_ff <= 1'b1;
         rResp_ff <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_SEL_FIRST: rData_ff <= sel_ff[0];
            ADDR_SEL_SECOND: rData_ff <= sel_ff[1];
            ADDR_CNT_EN: rData_ff <= {28'h0000000, cntEn_ff};
            ADDR_MODEL_GEN: rData_ff <= {28'h0000000, modelGen_ff};
            default: begin
               if (cnt_index(s_axi_araddr) < NUM_CNT) begin
                  rData_ff <= cnt_ff[cnt_index(s_axi_araddr)];
               end else begin
                  rData_ff <= 32'h0000_0000;
               end
            end
         endcase
      end else if (rValid_ff && s_axi_rready) begin
         rValid_ff <= 1'b0;
         arRdy_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awRdy_ff;
   assign s_axi_wready = wRdy_ff;
   assign s_axi_bvalid = bValid_ff;
   assign s_axi_bresp = bResp_ff;
   assign s_axi_arready = arRdy_ff;
   assign s_axi_rvalid = rValid_ff;
   assign s_axi_rresp = rResp_ff;
   assign s_axi_rdata = rData_ff;
   assign incPulse = inc_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks. Helper terms describe counter 0 on the first select register; o2 describes counter 3 on the second.
   logic q0;
   logic newGen;
   logic srcOk;
   logic d0;
   logic o2;

   assign q0 = evt_field(sel_ff[0]) == EVT_QUEUE_ALLOC && cntEn_ff[0];
   assign d0 = evt_field(sel_ff[0]) == EVT_DATA_ACT && cntEn_ff[0] && !wrFire;
   assign o2 = evt_field(sel_ff[1]) == EVT_DATA_ACT && cntEn_ff[3];
   assign newGen = modelGen_ff >= NEW_GEN_MIN;
   assign srcOk = ((sel_ff[0][MASK_LSB + QM_OWN] && alloc.ownAgent)
      || (sel_ff[0][MASK_LSB + QM_OTHER] && alloc.otherAgent))
      && !alloc.prefetch;

   a_new_gen_req: assert property (
      @(posedge clk) disable iff (!rstn) q0 && newGen && alloc.valid
      && (sel_ff[0][MASK_LSB + 4:MASK_LSB] != alloc.reqType
      || !(sel_ff[0][MASK_LSB + QM_ALL_READ] && alloc.isRead
      || sel_ff[0][MASK_LSB + QM_ALL_WRITE] && alloc.isWrite))
      |=> !incPulse[0]) else $error("new generation counted a bad type");
   a_old_gen_or: assert property (
      @(posedge clk) disable iff (!rstn) q0 && !newGen && alloc.valid
      && srcOk && sel_ff[0][MASK_LSB + 4:MASK_LSB] == alloc.reqType
      |=> incPulse[0]) else $error("old generation missed a type match");
   a_old_mem_drop: assert property (
      @(posedge clk) disable iff (!rstn) q0 && !newGen && alloc.valid
      && (sel_ff[0][MASK_LSB + QM_ALL_READ]
      || sel_ff[0][MASK_LSB + QM_ALL_WRITE])
      && sel_ff[0][MASK_LSB + 4:MASK_LSB] != alloc.reqType
      && !(sel_ff[0][MASK_LSB + QM_ALL_READ] && alloc.isRead)
      && !(sel_ff[0][MASK_LSB + QM_ALL_WRITE] && alloc.isWrite)
      |=> !incPulse[0]) else $error("memory bits were not dropped");
   a_user_counted: assert property (
      @(posedge clk) disable iff (!rstn) q0 && newGen && alloc.valid
      && alloc.userLevel && srcOk && nxt_inc[0] && !wrFire
      |=> incPulse[0] && cnt_ff[0] != $past(cnt_ff[0]))
      else $error("user level request not counted");
   a_chunk_weight: assert property (
      @(posedge clk) disable iff (!rstn) q0 && !wrFire && alloc.valid
      && !alloc.isLine && nxt_inc[0]
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 32'h0000_0001)
      else $error("chunk allocation miscounted");
   a_second_feeds: assert property (
      @(posedge clk) disable iff (!rstn) o2 && sel_ff[1][MASK_LSB + DM_OWN]
      && bus.dataReadyStrobe && bus.selfSamples
      |=> incPulse[3] && incPulse[2] == $past(cntEn_ff[2]))
      else $error("second select did not feed counters 2 and 3");
   a_drv_line_four: assert property (
      @(posedge clk) disable iff (!rstn) (d0 && sel_ff[0][MASK_LSB + DM_DRV]
      && bus.dataReadyStrobe && bus.selfDrives)[*4]
      |=> cnt_ff[0] == $past(cnt_ff[0], 4) + 32'h0000_0004)
      else $error("full line drive not counted four times");
   a_own_part_two: assert property (
      @(posedge clk) disable iff (!rstn) (d0 && sel_ff[0][MASK_LSB + DM_OWN]
      && bus.dataReadyStrobe && bus.selfSamples)[*2]
      |=> cnt_ff[0] == $past(cnt_ff[0], 2) + 32'h0000_0002)
      else $error("partial read not counted twice");
   a_other_line_four: assert property (
      @(posedge clk) disable iff (!rstn)
      (d0 && sel_ff[0][MASK_LSB + DM_OTHER]
      && bus.dataReadyStrobe && !bus.selfSamples)[*4]
      |=> cnt_ff[0] == $past(cnt_ff[0], 4) + 32'h0000_0004)
      else $error("other agent line not counted four times");
   a_field_split: assert property (
      @(posedge clk) disable iff (!rstn) evt_field(sel_ff[0]) != EVT_DATA_ACT
      && evt_field(sel_ff[0]) != EVT_QUEUE_ALLOC |=> !incPulse[0])
      else $error("unknown event select counted");

   c_data_count: cover property (@(posedge clk) disable iff (!rstn)
      d0 && nxt_inc[0]);
   c_queue_new: cover property (@(posedge clk) disable iff (!rstn)
      q0 && newGen && nxt_inc[0]);
   c_queue_old: cover property (@(posedge clk) disable iff (!rstn)
      q0 && !newGen && nxt_inc[0]);
   c_slverr: cover property (@(posedge clk) disable iff (!rstn)
      bValid_ff && bResp_ff == RESP_SLVERR);
endmodule // bq_top

// >>> sim/bq_bus_agent.sv
// Model of the bus agents, this end included, that raise the data-ready strobe.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module bq_bus_agent
   import bq_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Frame request from the bench.
   input wire logic start,
   input wire logic [1:0] kind,
   input wire logic isLine,
   // Bus view and frame status.
   output bq_bus_t bus,
   output logic busy
);
   logic [2:0] left_ff;

   assign busy = bus.dataReadyStrobe;

   // Outside a frame the qualifiers toggle every cycle, so a design that
   // counts them without the strobe shows up at once.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left_ff <= 3'h0;
         bus <= '0;
      end else if (start) begin
         left_ff <= isLine ? 3'(LINE_STROBE_CLKS - 1)
            : 3'(PART_STROBE_CLKS - 1);
         bus.dataReadyStrobe <= 1'b1;
         bus.selfDrives <= (kind == 2'h0);
         bus.selfSamples <= (kind == 2'h1);
      end else if (left_ff != 3'h0) begin
         left_ff <= left_ff - 3'h1;
      end else begin
         bus.dataReadyStrobe <= 1'b0;
         bus.dataBusyStrobe <= 1'b0;
         bus.selfDrives <= ~bus.selfDrives;
         bus.selfSamples <= ~bus.selfSamples;
      end
   end
endmodule // bq_bus_agent

// >>> sim/tb_bus_event_count_qualifier.sv
// Self-checking bench for the bus event count qualifier.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
   miscompares++; $display("wrong value at %0t: got %0h expected %0h", \
   $time, (g), (e)); end end
module tb_bus_event_count_qualifier
   import bq_pkg::*;
;
   logic clk, rstn, start, isLine, busy;
   logic [1:0] kind;
   bq_bus_t busView;
   bq_alloc_t allocIn, a;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, expCnt;
   logic [3:0] s_axi_wstrb, cntEn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [NUM_CNT-1:0] incPulse;
   int miscompares, samplesChecked;
   // Queue allocation cases: generation, mask, and per-case flag bytes.
   localparam logic [3:0] T_GEN [8] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1,
      4'h1, 4'h2};
   localparam logic [15:0] T_MASK [8] = '{16'h20A1, 16'h20A1, 16'h20A1,
      16'h20A1, 16'h2082, 16'h20C2, 16'h20A1, 16'h20A1};
   localparam logic [7:0] T_WB = 8'h0C;
   localparam logic [7:0] T_WR = 8'h80;
   localparam logic [7:0] T_OTHER = 8'h40;
   localparam logic [7:0] T_USER = 8'hFD;
   localparam logic [7:0] T_LINE = 8'h01;
   localparam logic [7:0] T_HIT = 8'h1B;

   bq_top dut_u (.clk(clk), .rstn(rstn), .bus(busView), .alloc(allocIn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .incPulse(incPulse));

   bq_bus_agent agent_u (.clk(clk), .rstn(rstn), .start(start),
      .kind(kind), .isLine(isLine), .bus(busView), .busy(busy));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic axWrite(input logic [7:0] ad, input logic [31:0] d,
      input logic [1:0] expResp);
      logic got;
      got = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            got = 1'b1;
            s_axi_bready <= 1'b0;
            `CHK(s_axi_bresp, expResp)
         end
      end
   endtask

   task automatic axRead(input logic [7:0] ad, output logic [31:0] d,
      input logic [1:0] expResp);
      logic got;
      got = 1'b0;
      @(posedge clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            got = 1'b1;
            d = s_axi_rdata;
            s_axi_rready <= 1'b0;
            `CHK(s_axi_rresp, expResp)
         end
      end
   endtask

   task automatic runFrame(input logic [1:0] k, input logic ln);
      @(posedge clk);
      start <= 1'b1;
      kind <= k;
      isLine <= ln;
      @(posedge clk);
      start <= 1'b0;
      #1;
      while (busy) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      conclude();
   end

   initial begin
      rstn = 1'b0;
      {start, kind, isLine} = '0;
      allocIn = '0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      // Reset values, then an unmapped place and a select readback.
      for (int i = 0; i < 8; i++) begin
         axRead(8'(4 * i), rd, RESP_OKAY);
         `CHK(rd, (i == 3) ? 32'h0000_0002 : 32'h0000_0000)
      end
      axWrite(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
      axRead(8'h20, rd, RESP_SLVERR);
      `CHK(rd, 32'h0000_0000)
      axWrite(ADDR_SEL_FIRST, 32'hA5C3_5A3C, RESP_OKAY);
      axRead(ADDR_SEL_FIRST, rd, RESP_OKAY);
      `CHK(rd, 32'hA5C3_5A3C)
      $display("register test done");
      // Counter 2 stays disabled, so its select must not reach it.
      cntEn = 4'hB;
      axWrite(ADDR_CNT_EN, {28'h0, cntEn}, RESP_OKAY);
      for (int m = 0; m < 3; m++) begin
         axWrite(ADDR_SEL_FIRST, {EVT_DATA_ACT, 16'(1 << m), 9'h0},
            RESP_OKAY);
         axWrite(ADDR_SEL_SECOND, {EVT_DATA_ACT, 16'(1 << m), 9'h0},
            RESP_OKAY);
         for (int k = 0; k < 3; k++) begin
            for (int ln = 0; ln < 2; ln++) begin
               for (int c = 0; c < 4; c++) begin
                  axWrite(ADDR_CNT_BASE + 8'(4 * c), 32'h0, RESP_OKAY);
               end
               runFrame(2'(k), ln[0]);
               expCnt = (m == k || (m == 2 && k != 1)) ? 32'((ln == 1) ?
                  LINE_STROBE_CLKS : PART_STROBE_CLKS) : 32'h0;
               for (int c = 0; c < 4; c++) begin
                  axRead(ADDR_CNT_BASE + 8'(4 * c), rd, RESP_OKAY);
                  `CHK(rd, cntEn[c] ? expCnt : 32'h0)
               end
            end
         end
      end
      $display("data activity test done");
      for (int i = 0; i < 8; i++) begin
         axWrite(ADDR_MODEL_GEN, {28'h0, T_GEN[i]}, RESP_OKAY);
         axWrite(ADDR_SEL_FIRST, {EVT_QUEUE_ALLOC, T_MASK[i], 9'h0},
            RESP_OKAY);
         axWrite(ADDR_CNT_BASE, 32'h0, RESP_OKAY);
         a = '0;
         a.valid = 1'b1;
         a.reqType = 5'h01;
         a.isRead = !T_WR[i];
         a.isWrite = T_WR[i];
         a.memType = T_WB[i] ? 5'h10 : 5'h01;
         a.ownAgent = !T_OTHER[i];
         a.otherAgent = T_OTHER[i];
         a.userLevel = T_USER[i];
         a.isLine = T_LINE[i];
         @(posedge clk);
         allocIn <= a;
         @(posedge clk);
         allocIn <= '0;
         #1;
         `CHK(incPulse, {2'b00, {2{T_HIT[i]}}})
         repeat (2) @(posedge clk);
         axRead(ADDR_CNT_BASE, rd, RESP_OKAY);
         `CHK(rd, {31'h0, T_HIT[i]})
      end
      $display("queue allocation test done");
      conclude();
   end
endmodule // tb_bus_event_count_qualifier
